// ### src/lcd_pkg.sv
// shared constants of the bit-map lcd command core
package lcd_pkg;

  // ***********************************************************
  // register offsets (apb byte addresses)
  // ***********************************************************
  localparam logic [7:0] INSTR_OFS = 8'h00; // write: instruction, read: status
  localparam logic [7:0] DATA_OFS = 8'h04; // display data write / read
  localparam logic [7:0] STATE_OFS = 8'h08; // read-only core state

  // ***********************************************************
  // status byte and state word field positions
  // ***********************************************************
  localparam int STAT_BUSY = 7;
  localparam int STAT_ADC = 6;
  localparam int STAT_OFF = 5;
  localparam int STAT_RESET = 4;
  localparam int ST_BUS80 = 0;
  localparam int ST_MASTER = 1;
  localparam int ST_DUTY32 = 2;
  localparam int ST_STATIC = 3;
  localparam int ST_RMW = 4;
  localparam int ST_PSAVE = 5;
  localparam int ST_PAGE = 8;
  localparam int ST_COL = 16;
  localparam int ST_START = 24;

  // ***********************************************************
  // memory geometry and initialisation values
  // ***********************************************************
  localparam int COLS = 80;
  localparam int PAGES = 4;
  localparam logic [6:0] COL_LOCK = 7'h50;
  localparam logic [6:0] COL_INIT = 7'h00;
  localparam logic [4:0] START_INIT = 5'h00;
  localparam logic [1:0] PAGE_INIT = 2'h3;
  localparam logic DUTY32_INIT = 1'b1;
  localparam logic ADC_INV_INIT = 1'b1;
  localparam logic DISPLAY_ON_INIT = 1'b0;
  localparam logic STATIC_INIT = 1'b0;
  localparam logic RMW_INIT = 1'b0;
  localparam logic [4:0] LAST_COM_16 = 5'h0F;
  localparam logic [4:0] LAST_COM_32 = 5'h1F;
  localparam logic [4:0] HALF_COM = 5'h10;

  // ***********************************************************
  // instruction codes (upper bits that identify each one; whole byte for rmw, end and reset)
  // ***********************************************************
  localparam logic [6:0] OP_DISPLAY = 7'h57;
  localparam logic [6:0] OP_ADC = 7'h50;
  localparam logic [6:0] OP_STATIC = 7'h52;
  localparam logic [6:0] OP_DUTY = 7'h54;
  localparam logic [2:0] OP_START = 3'h6;
  localparam logic [5:0] OP_PAGE = 6'h2E;
  localparam logic [7:0] OP_RMW = 8'hE0;
  localparam logic [7:0] OP_END = 8'hEE;
  localparam logic [7:0] OP_RESET = 8'hE2;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int BUSY_TIME_NS = 24;
  localparam int INIT_TIME_NS = 80;
  localparam logic [3:0] BUSY_CYCLES =
    4'((BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] INIT_CYCLES =
    4'((INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// ### src/lcd_timing_if.sv
// signals between the command core and its display timing generator
interface lcd_timing_if;
  logic lcd_clk_level;
  logic frame_in_level;
  logic master;
  logic duty_32;
  logic strobe;
  logic flip;
  logic frame_level;
  logic [4:0] common_index;

  modport core (
    output lcd_clk_level,
    output frame_in_level,
    output master,
    output duty_32,
    input strobe,
    input flip,
    input frame_level,
    input common_index
  );

  modport gen (
    input lcd_clk_level,
    input frame_in_level,
    input master,
    input duty_32,
    output strobe,
    output flip,
    output frame_level,
    output common_index
  );
endinterface

// ### src/lcd_timing_gen.sv
// common scan and frame timing generator for master or slave use
module lcd_timing_gen (
  input wire logic mclk,
  input wire logic rst,
  lcd_timing_if.gen tif
);

  logic clk_d;
  logic frame_d;
  logic [4:0] cnt;
  logic [4:0] last;
  logic tick;
  logic frame_edge;

  // end of the scan follows the selected duty
  assign last = tif.duty_32 ? lcd_pkg::LAST_COM_32 : lcd_pkg::LAST_COM_16;
  assign tick = tif.lcd_clk_level & ~clk_d;
  assign frame_edge = tif.frame_in_level ^ frame_d;

  // edge history of the already synchronised levels
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clk_d <= 1'b0;
      frame_d <= 1'b0;
    end else begin
      clk_d <= tif.lcd_clk_level;
      frame_d <= tif.frame_in_level;
    end
  end

  // scan counter; master makes the frame signal, slave follows it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 5'h00;
      tif.common_index <= 5'h00;
      tif.strobe <= 1'b0;
      tif.flip <= 1'b0;
      tif.frame_level <= 1'b0;
    end else begin
      tif.strobe <= 1'b0;
      tif.flip <= 1'b0;
      if (tif.master) begin
        if (tick) begin
          tif.common_index <= cnt;
          tif.strobe <= 1'b1;
          if (cnt == 5'h00) begin
            // toggling once a frame gives a 50% square wave
            tif.frame_level <= ~tif.frame_level;
            tif.flip <= 1'b1;
          end
          cnt <= (cnt >= last) ? 5'h00 : cnt + 5'h01;
        end
      end else begin
        tif.frame_level <= tif.frame_in_level;
        if (frame_edge) begin
          // master has already shown line 0 when the edge arrives here
          cnt <= 5'h01;
          tif.flip <= 1'b1;
        end else if (tick) begin
          tif.common_index <= cnt;
          tif.strobe <= 1'b1;
          cnt <= (cnt >= last) ? last : cnt + 5'h01;
        end
      end
    end
  end

endmodule

// ### src/bitmap_lcd_command_core.sv
// bit-map lcd command core: apb access, display memory and line scan
module bitmap_lcd_command_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lcd_clk_pin,
  input wire logic reset_pin,
  input wire logic master_select_pin,
  input wire logic frame_in_pin,
  output logic frame_alternation_signal,
  output logic frame_alternation_oe,
  output logic [15:0] common_scan_output,
  output logic [79:0] segment_output,
  output logic line_latch_strobe,
  output logic power_save,
  output logic bus_type_80
);

  // ***********************************************************
  // pin synchronisers
  // ***********************************************************
  logic [1:0] lcd_clk_s;
  logic [1:0] rst_pin_s;
  logic [1:0] ms_s;
  logic [1:0] frame_s;
  logic rst_pin_d;
  logic init_req;

  // two flops per pin; only stage 1 is read by logic
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lcd_clk_s <= 2'h0;
      rst_pin_s <= 2'h0;
      ms_s <= 2'h0;
      frame_s <= 2'h0;
      rst_pin_d <= 1'b0;
    end else begin
      lcd_clk_s <= {lcd_clk_s[0], lcd_clk_pin};
      rst_pin_s <= {rst_pin_s[0], reset_pin};
      ms_s <= {ms_s[0], master_select_pin};
      frame_s <= {frame_s[0], frame_in_pin};
      rst_pin_d <= rst_pin_s[1];
    end
  end

  // either edge of the reset pin starts a full initialisation
  assign init_req = rst_pin_s[1] ^ rst_pin_d;

  // ***********************************************************
  // core state
  // ***********************************************************
  logic [7:0] ram [lcd_pkg::PAGES][lcd_pkg::COLS];
  logic [79:0] line_latch;
  logic [79:0] mapped;
  logic [7:0] read_buf;
  logic [6:0] column;
  logic [1:0] page;
  logic [4:0] start_line;
  logic [4:0] line_cnt;
  logic [4:0] line_src;
  logic display_on;
  logic static_on;
  logic duty_32;
  logic adc_inv;
  logic rmw;
  logic [3:0] busy_cnt;
  logic busy_flag;
  logic reset_flag;
  logic psave;

  assign busy_flag = (busy_cnt != 4'h0);
  assign psave = ~display_on & static_on;

  // ***********************************************************
  // apb slave and access decode
  // ***********************************************************
  logic access;
  logic is_instr;
  logic is_data;
  logic is_state;
  logic [7:0] wb;
  logic cmd_ok;
  logic dwr_ok;
  logic drd_ok;
  logic [7:0] status_byte;
  logic [31:0] state_word;

  assign access = psel & penable & pready;
  assign is_instr = (paddr == lcd_pkg::INSTR_OFS);
  assign is_data = (paddr == lcd_pkg::DATA_OFS);
  assign is_state = (paddr == lcd_pkg::STATE_OFS);
  assign wb = pwdata[7:0];
  // anything but a status or state read is dropped while busy
  assign cmd_ok = access & pwrite & is_instr & ~busy_flag;
  assign dwr_ok = access & pwrite & is_data & ~busy_flag;
  assign drd_ok = access & ~pwrite & is_data & ~busy_flag;

  // status byte, low nibble zero
  always_comb begin
    status_byte = 8'h00;
    status_byte[lcd_pkg::STAT_BUSY] = busy_flag;
    status_byte[lcd_pkg::STAT_ADC] = adc_inv;
    status_byte[lcd_pkg::STAT_OFF] = ~display_on;
    status_byte[lcd_pkg::STAT_RESET] = reset_flag;
  end

  // read-only view of the core for software
  always_comb begin
    state_word = 32'h0000_0000;
    state_word[lcd_pkg::ST_BUS80] = bus_type_80;
    state_word[lcd_pkg::ST_MASTER] = ms_s[1];
    state_word[lcd_pkg::ST_DUTY32] = duty_32;
    state_word[lcd_pkg::ST_STATIC] = static_on;
    state_word[lcd_pkg::ST_RMW] = rmw;
    state_word[lcd_pkg::ST_PSAVE] = psave;
    state_word[lcd_pkg::ST_PAGE +: 2] = page;
    state_word[lcd_pkg::ST_COL +: 7] = column;
    state_word[lcd_pkg::ST_START +: 5] = start_line;
  end

  // one wait state: pready rises one edge after the access phase opens
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~(is_instr | is_data | is_state);
      if (psel & penable & ~pready & ~pwrite) begin
        if (is_instr) begin
          prdata <= {24'h00_0000, status_byte};
        end else if (is_data) begin
          prdata <= {24'h00_0000, read_buf};
        end else if (is_state) begin
          prdata <= state_word;
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

  // ***********************************************************
  // busy, reset period and bus type
  // ***********************************************************
  // init wins over any access that lands in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_cnt <= 4'h0;
      reset_flag <= 1'b0;
    end else if (init_req || (cmd_ok && wb == lcd_pkg::OP_RESET)) begin
      busy_cnt <= lcd_pkg::INIT_CYCLES;
      reset_flag <= 1'b1;
    end else if (cmd_ok || dwr_ok || drd_ok) begin
      busy_cnt <= lcd_pkg::BUSY_CYCLES;
    end else if (busy_flag) begin
      busy_cnt <= busy_cnt - 4'h1;
      if (busy_cnt == 4'h1) begin
        reset_flag <= 1'b0;
      end
    end
  end

  // the pin level that stands at the end of the reset period is the bus type
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_type_80 <= 1'b0;
    end else if (reset_flag && busy_cnt == 4'h1) begin
      bus_type_80 <= rst_pin_s[1];
    end
  end

  // ***********************************************************
  // instruction execution
  // ***********************************************************
  // display, static, duty, mapping and read-modify-write settings
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      display_on <= lcd_pkg::DISPLAY_ON_INIT;
      static_on <= lcd_pkg::STATIC_INIT;
      duty_32 <= lcd_pkg::DUTY32_INIT;
      adc_inv <= lcd_pkg::ADC_INV_INIT;
      rmw <= lcd_pkg::RMW_INIT;
    end else if (init_req) begin
      display_on <= lcd_pkg::DISPLAY_ON_INIT;
      static_on <= lcd_pkg::STATIC_INIT;
      duty_32 <= lcd_pkg::DUTY32_INIT;
      adc_inv <= lcd_pkg::ADC_INV_INIT;
      rmw <= lcd_pkg::RMW_INIT;
    end else if (cmd_ok) begin
      if (wb[7:1] == lcd_pkg::OP_DISPLAY) begin
        display_on <= wb[0];
      end
      if (wb[7:1] == lcd_pkg::OP_STATIC) begin
        static_on <= wb[0];
      end
      if (wb[7:1] == lcd_pkg::OP_DUTY) begin
        duty_32 <= wb[0];
      end
      if (wb[7:1] == lcd_pkg::OP_ADC) begin
        adc_inv <= ~wb[0];
      end
      if (wb == lcd_pkg::OP_RMW) begin
        rmw <= 1'b1;
      end
      if (wb == lcd_pkg::OP_END) begin
        rmw <= 1'b0;
      end
    end
  end

  // start line and page; besides the reset period, the reset instruction touches only these
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      start_line <= lcd_pkg::START_INIT;
      page <= lcd_pkg::PAGE_INIT;
    end else if (init_req || (cmd_ok && wb == lcd_pkg::OP_RESET)) begin
      start_line <= lcd_pkg::START_INIT;
      page <= lcd_pkg::PAGE_INIT;
    end else if (cmd_ok) begin
      if (wb[7:5] == lcd_pkg::OP_START) begin
        start_line <= wb[4:0];
      end
      if (wb[7:2] == lcd_pkg::OP_PAGE) begin
        page <= wb[1:0];
      end
    end
  end

  // column counter: preset, step on data write and on data read outside rmw, lock at the last+1
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      column <= lcd_pkg::COL_INIT;
    end else if (init_req) begin
      column <= lcd_pkg::COL_INIT;
    end else if (cmd_ok && !wb[7]) begin
      column <= wb[6:0];
    end else if (dwr_ok || (drd_ok && !rmw)) begin
      if (column != lcd_pkg::COL_LOCK) begin
        column <= column + 7'h01;
      end
    end
  end

  // ***********************************************************
  // display memory and read buffer
  // ***********************************************************
  // host writes; the refresh side only reads, so neither disturbs the other
  always_ff @(posedge mclk) begin
    if (dwr_ok && column < lcd_pkg::COL_LOCK) begin
      ram[page][column] <= wb;
    end
  end

  // reads return the buffer, then refill it: stale after a column set
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      read_buf <= 8'h00;
    end else if (drd_ok) begin
      if (column < lcd_pkg::COL_LOCK) begin
        read_buf <= ram[page][column];
      end else begin
        read_buf <= 8'h00;
      end
    end
  end

  // ***********************************************************
  // display timing and line scan
  // ***********************************************************
  lcd_timing_if tif();

  assign tif.lcd_clk_level = lcd_clk_s[1];
  assign tif.frame_in_level = frame_s[1];
  assign tif.master = ms_s[1];
  assign tif.duty_32 = duty_32;

  lcd_timing_gen u_timing (
    .mclk(mclk),
    .rst(rst),
    .tif(tif.gen)
  );

  // at a frame flip the scan restarts from the start line
  assign line_src = tif.flip ? start_line : line_cnt;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      line_cnt <= lcd_pkg::START_INIT;
    end else if (tif.strobe) begin
      line_cnt <= line_src + 5'h01;
    end else if (tif.flip) begin
      line_cnt <= start_line + 5'h01;
    end
  end

  // one memory line per common period into the line latch
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      line_latch <= 80'h0;
    end else if (tif.strobe) begin
      for (int c = 0; c < lcd_pkg::COLS; c++) begin
        line_latch[c] <= ram[line_src[4:3]][c][line_src[2:0]];
      end
    end
  end

  // column to segment mapping
  always_comb begin
    mapped = 80'h0;
    for (int n = 0; n < lcd_pkg::COLS; n++) begin
      mapped[n] = adc_inv ? line_latch[lcd_pkg::COLS - 1 - n]
                          : line_latch[n];
    end
  end

  // drivers: display off blanks the segments, the static all-on level included
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      segment_output <= 80'h0;
      power_save <= 1'b0;
      line_latch_strobe <= 1'b0;
    end else begin
      power_save <= psave;
      line_latch_strobe <= tif.strobe;
      if (psave || !display_on) begin
        segment_output <= 80'h0;
      end else if (static_on) begin
        segment_output <= {80{1'b1}};
      end else begin
        segment_output <= mapped;
      end
    end
  end

  // common outputs; the slave serves the upper half in reverse order
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      common_scan_output <= 16'h0000;
    end else begin
      common_scan_output <= 16'h0000;
      if (psave) begin
        common_scan_output <= 16'h0000;
      end else if (static_on) begin
        common_scan_output <= 16'hFFFF;
      end else if (ms_s[1]) begin
        if (tif.common_index < lcd_pkg::HALF_COM) begin
          common_scan_output[tif.common_index[3:0]] <= 1'b1;
        end
      end else if (tif.common_index >= lcd_pkg::HALF_COM) begin
        common_scan_output[~tif.common_index[3:0]] <= 1'b1;
      end
    end
  end

  // frame signal is driven out only by the master
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      frame_alternation_signal <= 1'b0;
      frame_alternation_oe <= 1'b0;
    end else begin
      frame_alternation_signal <= tif.frame_level;
      frame_alternation_oe <= ms_s[1];
    end
  end

endmodule

// ### sim/lcd_clk_source.sv
// line clock and frame input source facing the lcd core pins
module lcd_clk_source (
  input wire logic mclk,
  input wire logic en,
  output logic lcd_clk_pin,
  output logic frame_in_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] div = 4'h0;
  logic [4:0] lines = 5'h00;
  // gated source: the line clock stands still low while disabled
  always @(posedge mclk) begin
    if (en) div <= div + 4'h1;
    if (en && div == 4'hF) lines <= lines + 5'h01;
  end
  assign lcd_clk_pin = en && div[3];
  assign frame_in_pin = lines[4]; // square wave, flips every 16 lines
endmodule

// ### sim/lcd_core_checker.sv
// port assertions for the lcd command core
module lcd_core_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic master_select_pin,
  input wire logic frame_alternation_oe,
  input wire logic [15:0] common_scan_output,
  input wire logic [79:0] segment_output,
  input wire logic line_latch_strobe,
  input wire logic power_save
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ****
  // bus answer
  // ****
  a_one_wait: assert property (
    psel && penable && !pready |=> pready) else $error("no answer");
  a_ready_pulse: assert property (
    pready |=> !pready) else $error("pready too long");
  a_unmapped_err: assert property (
    pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}))
    else $error("pslverr wrong");
  a_status_low: assert property (
    pready && !pwrite && paddr == 8'h00 |-> prdata[31:8] == 24'h0
    && prdata[3:0] == 4'h0) else $error("status low bits set");
  a_data_byte: assert property (
    pready && !pwrite && paddr == 8'h04 |-> prdata[31:8] == 24'h0)
    else $error("data upper bits set");
  // ****
  // display side
  // ****
  a_psave_dark: assert property (
    power_save |-> common_scan_output == 16'h0 && segment_output == 80'h0)
    else $error("outputs live in power save");
  a_latch_pulse: assert property (
    line_latch_strobe |=> !line_latch_strobe) else $error("latch strobe long");
  a_master_oe: assert property (
    master_select_pin [*6] |-> frame_alternation_oe)
    else $error("master not driving frame");
  c_status: cover property (pready && !pwrite && paddr == 8'h00);
  c_data_wr: cover property (pready && pwrite && paddr == 8'h04);
  c_psave: cover property (power_save);
endmodule
bind bitmap_lcd_command_core lcd_core_checker u_chk (.*);

// ### sim/bitmap_lcd_command_core_tb.sv
// self-checking bench for the lcd command core
module bitmap_lcd_command_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, lcd_clk_pin, frame_in_pin, frame_alternation_signal;
  logic frame_alternation_oe, line_latch_strobe, power_save, bus_type_80;
  logic reset_pin = 1'b0, master_select_pin = 1'b1, en = 1'b0, err, f;
  logic [15:0] common_scan_output;
  logic [79:0] segment_output;
  int failures = 0, compares = 0, cyc = 0;
  always #4 mclk = ~mclk;
  bitmap_lcd_command_core DUT (.*);
  lcd_clk_source u_src (.mclk(mclk), .en(en), .lcd_clk_pin(lcd_clk_pin),
    .frame_in_pin(frame_in_pin));
  // ****
  // tasks
  // ****
  task automatic tally_and_finish();
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  // keep leaves psel up so the next setup follows at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic keep);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1 && ++n < 50);
    if (pready !== 1'b1) failures++;
    r = prdata;
    err = pslverr;
    penable <= 1'b0;
    if (!keep) begin
      psel <= 1'b0;
      @(posedge mclk);
    end
  endtask
  // poll status bit 7 instead of trusting a fixed spacing
  task automatic idle();
    int n;
    n = 0;
    do apb(1'b0, 8'h00, 8'h00, 1'b0); while (r[7] !== 1'b0 && ++n < 30);
  endtask
  task automatic acc(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 1'b0);
    idle();
  endtask
  task automatic ex(input string s, input logic [7:0] a,
                    input logic [31:0] e);
    apb(1'b0, a, 8'h00, 1'b0);
    chk(s, e, r);
    idle();
  endtask
  // wait for the next arrival of the first common
  task automatic row0();
    int n;
    n = 0;
    while (common_scan_output === 16'h0001 && ++n < 900) @(posedge mclk);
    while (common_scan_output !== 16'h0001 && ++n < 900) @(posedge mclk);
    repeat (3) @(posedge mclk);
  endtask
  // slave: skip what the master left lit, then find the first lit common
  task automatic slave_first();
    int n;
    n = 0;
    while (common_scan_output !== 16'h0000 && ++n < 900) @(posedge mclk);
    while (common_scan_output === 16'h0000 && ++n < 900) @(posedge mclk);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      tally_and_finish();
    end
  end
  // ****
  // main sequence
  // ****
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (5) @(posedge mclk);
    ex("init state", 8'h08, 32'h0000_0306);
    ex("init status", 8'h00, 32'h60);
    acc(8'h00, 8'hAF);
    ex("display on", 8'h00, 32'h40);
    acc(8'h00, 8'hA1);
    ex("normal map", 8'h00, 32'h00);
    apb(1'b1, 8'h00, 8'hB9, 1'b1);
    apb(1'b0, 8'h00, 8'h00, 1'b0);
    chk("busy bit", 32'h1, 32'(r[7]));
    idle();
    apb(1'b1, 8'h00, 8'hBA, 1'b1);
    apb(1'b1, 8'h00, 8'hBB, 1'b0);
    idle();
    ex("refused", 8'h08, 32'h0000_0206);
    acc(8'h00, 8'hB8);
    acc(8'h00, 8'h4E);
    acc(8'h04, 8'h11);
    acc(8'h04, 8'h22);
    acc(8'h04, 8'h33);
    ex("col lock", 8'h08, 32'h0050_0006);
    acc(8'h00, 8'h4E);
    apb(1'b0, 8'h04, 8'h00, 1'b0);
    idle();
    ex("rd 4e", 8'h04, 32'h11);
    ex("rd 4f", 8'h04, 32'h22);
    ex("rd 50", 8'h04, 32'h00);
    acc(8'h00, 8'hE0);
    acc(8'h00, 8'h4E);
    apb(1'b0, 8'h04, 8'h00, 1'b0);
    idle();
    ex("rmw rd", 8'h04, 32'h11);
    ex("rmw rd2", 8'h04, 32'h11);
    acc(8'h04, 8'h55);
    ex("rmw col", 8'h08, 32'h004F_0016);
    acc(8'h00, 8'hEE);
    apb(1'b0, 8'h04, 8'h00, 1'b0);
    idle();
    acc(8'h00, 8'hC5);
    acc(8'h00, 8'hB9);
    apb(1'b1, 8'h00, 8'hE2, 1'b1);
    apb(1'b0, 8'h00, 8'h00, 1'b0);
    chk("reset period", 32'h90, r & 32'h90);
    idle();
    ex("reset instr", 8'h08, 32'h0050_0306);
    acc(8'h00, 8'hAE);
    acc(8'h00, 8'hA5);
    chk("psave", 32'h1, 32'(power_save));
    ex("psave state", 8'h08, 32'h0050_032E);
    acc(8'h00, 8'hA4);
    chk("psave off", 32'h0, 32'(power_save));
    // one lit dot at line 0, column 0; column 1 written dark so no x shows
    acc(8'h00, 8'hB8);
    acc(8'h00, 8'h00);
    acc(8'h04, 8'h01);
    acc(8'h04, 8'h00);
    acc(8'h00, 8'hA8);
    acc(8'h00, 8'hAF);
    en <= 1'b1;
    row0();
    chk("normal seg", 32'h1, 32'(segment_output[1:0]));
    chk("first common", 32'h1, 32'(common_scan_output));
    chk("master oe", 32'h1, 32'(frame_alternation_oe));
    f = frame_alternation_signal;
    acc(8'h00, 8'hA0);
    row0();
    chk("inverse seg", 32'h2, 32'(segment_output[79:78]));
    chk("frame flip", {31'h0, ~f}, 32'(frame_alternation_signal));
    reset_pin <= 1'b1;
    repeat (20) @(posedge mclk);
    ex("pin init", 8'h08, 32'h0000_0307);
    ex("pin status", 8'h00, 32'h60);
    reset_pin <= 1'b0;
    repeat (20) @(posedge mclk);
    chk("bus 68", 32'h0, 32'(bus_type_80));
    apb(1'b1, 8'h08, 8'hFF, 1'b0);
    ex("ro state", 8'h08, 32'h0000_0306);
    apb(1'b0, 8'h0C, 8'h00, 1'b0);
    chk("unmapped", 32'h1, 32'(err));
    // slave at 1/32 duty: first lit pin of its half is the top one
    master_select_pin <= 1'b0;
    repeat (5) @(posedge mclk);
    slave_first();
    chk("slave common", 32'h8000, 32'(common_scan_output));
    chk("slave oe", 32'h0, 32'(frame_alternation_oe));
    tally_and_finish();
  end
endmodule
